// ==== rtl/charger_state_control.sv ====
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
module charger_state_control #(
  parameter int PRECHARGE_CYCLES = charger_pkg::PRECHARGE_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire charger_pkg::sense_t i_sense,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output var charger_pkg::drive_t o_drive,
  output logic o_irq
);

  // ==========================================================
  // input synchronisers
  charger_pkg::sense_t sense;
  sync2 #(.W($bits(charger_pkg::sense_t))) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_d(i_sense),
    .o_q(sense)
  );

  // ==========================================================
  // bus slave state
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] control_r, control_nxt;
  logic [charger_pkg::EV_W-1:0] event_r, event_nxt;
  logic [charger_pkg::EV_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [charger_pkg::EV_W-1:0] ev_set;
  logic [charger_pkg::EV_W-1:0] ev_clr;
  logic [31:0] status_word;

  // ==========================================================
  // charger state
  charger_pkg::charge_state_t state_r, state_nxt;
  logic [charger_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic [charger_pkg::FC_W-1:0] target_r, target_nxt;
  logic [15:0] fold_cnt_r, fold_cnt_nxt;
  logic suspend_r, suspend_nxt;
  logic shut_r, shut_nxt;
  charger_pkg::drive_t drive_r, drive_nxt;

  logic suspend;
  logic [charger_pkg::FC_W-1:0] fc_set;
  logic [charger_pkg::FC_W-1:0] floor;
  logic boost_en;

  assign fc_set = control_r[charger_pkg::CTL_FC_LSB +: charger_pkg::FC_W];
  assign floor = fc_set >> 2; // quarter of the programmed current
  assign boost_en = control_r[charger_pkg::CTL_BOOST_BIT];
  // grounded sensor overrides the window comparator
  assign suspend = i_rst ? 1'b0 :
    (sense.thermistor_out_of_range & ~sense.thermistor_grounded);

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    if (!sense.input_valid) begin
      state_nxt = charger_pkg::ST_DISABLED;
    end else begin
      unique case (state_r)
        charger_pkg::ST_DISABLED: begin
          timer_nxt = '0;
          state_nxt = sense.above_low ? charger_pkg::ST_PRECHARGE
                                      : charger_pkg::ST_DEAD_BATTERY;
        end
        charger_pkg::ST_DEAD_BATTERY: begin
          timer_nxt = '0;
          if (sense.above_low) begin
            state_nxt = charger_pkg::ST_PRECHARGE;
          end
        end
        charger_pkg::ST_PRECHARGE: begin
          if (sense.above_high) begin
            state_nxt = charger_pkg::ST_FAST_CC;
          end else if (!suspend) begin
            // held while suspended, no fault from the pause
            if (timer_r >= charger_pkg::TIMER_W'(PRECHARGE_CYCLES - 1)) begin
              state_nxt = charger_pkg::ST_TIMER_FAULT;
            end else begin
              timer_nxt = timer_r + 1'b1;
            end
          end
        end
        charger_pkg::ST_FAST_CC: begin
          state_nxt = charger_pkg::ST_FAST_CC;
        end
        charger_pkg::ST_TIMER_FAULT: begin
          state_nxt = charger_pkg::ST_TIMER_FAULT;
        end
        default: begin
          state_nxt = charger_pkg::ST_DISABLED;
        end
      endcase
    end
  end

  // ==========================================================
  // die temperature foldback
  always_comb begin
    target_nxt = target_r;
    fold_cnt_nxt = fold_cnt_r;
    shut_nxt = sense.die_over_shutdown;
    if (!sense.die_over_regulation) begin
      target_nxt = fc_set;
      fold_cnt_nxt = '0;
    end else if (target_r > floor) begin
      if (fold_cnt_r >= 16'(charger_pkg::FOLD_STEP_CYC - 1)) begin
        fold_cnt_nxt = '0;
        target_nxt = target_r - 1'b1;
      end else begin
        fold_cnt_nxt = fold_cnt_r + 1'b1;
      end
    end else begin
      target_nxt = floor;
    end
  end

  // ==========================================================
  // outputs to the analog side
  always_comb begin
    drive_nxt = '0;
    suspend_nxt = suspend;
    drive_nxt.current_target = target_r;
    // boost needs software enable, never started on its own
    drive_nxt.boost_on = ~sense.input_valid & boost_en;
    // paths drop with the input, on the same edge as state_r goes to ST_DISABLED
    if (sense.input_valid && !suspend && !shut_r) begin
      unique case (state_r)
        charger_pkg::ST_DEAD_BATTERY: begin
          drive_nxt.dead_battery_linear = 1'b1;
        end
        charger_pkg::ST_PRECHARGE: begin
          drive_nxt.dead_battery_linear = 1'b1;
          drive_nxt.system_linear = 1'b1;
        end
        charger_pkg::ST_FAST_CC: begin
          drive_nxt.switcher_on = 1'b1;
        end
        default: begin
          drive_nxt.switcher_on = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // events
  always_comb begin
    ev_set = '0;
    ev_set[charger_pkg::EV_STATE] = (state_nxt != state_r);
    ev_set[charger_pkg::EV_TIMER_FAULT] =
      (state_nxt == charger_pkg::ST_TIMER_FAULT) &&
      (state_r != charger_pkg::ST_TIMER_FAULT);
    ev_set[charger_pkg::EV_TEMP_SUSPEND] = suspend & ~suspend_r;
    ev_set[charger_pkg::EV_DIE_SHUTDOWN] = sense.die_over_shutdown & ~shut_r;
    ev_clr = '0;
    if (wr_pend_r && (wr_addr_r == charger_pkg::EVENT_ADDR)) begin
      ev_clr = i_hwdata[charger_pkg::EV_W-1:0];
    end
  end

  // ==========================================================
  // sticky event bits
  // set wins over a clear in the same cycle, so no event is lost
  for (genvar gi = 0; gi < charger_pkg::EV_W; gi++) begin : g_event
    assign event_nxt[gi] = ev_set[gi] | (event_r[gi] & ~ev_clr[gi]);
  end

  // ==========================================================
  // register writes, applied in the data phase
  always_comb begin
    control_nxt = control_r;
    mask_nxt = mask_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        charger_pkg::CONTROL_ADDR: control_nxt = i_hwdata;
        charger_pkg::MASK_ADDR: mask_nxt = i_hwdata[charger_pkg::EV_W-1:0];
        default: control_nxt = control_r;
      endcase
    end
  end

  // ==========================================================
  // address phase and read data
  assign status_word = {26'h000_0000, suspend_r, shut_r, 1'b0, state_r};

  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    if (i_hsel && i_hready && i_htrans[1]) begin
      wr_pend_nxt = i_hwrite;
      wr_addr_nxt = i_haddr[7:0];
      // next values, so a read right behind a write sees that write
      unique case (i_haddr[7:0])
        charger_pkg::CONTROL_ADDR: rdata_nxt = control_nxt;
        charger_pkg::STATUS_ADDR: rdata_nxt = status_word;
        charger_pkg::EVENT_ADDR: rdata_nxt = {28'h000_0000, event_nxt};
        charger_pkg::MASK_ADDR: rdata_nxt = {28'h000_0000, mask_nxt};
        charger_pkg::TIMER_ADDR: rdata_nxt = timer_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // charger state registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= charger_pkg::ST_DISABLED;
      timer_r <= '0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // ==========================================================
  // foldback registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      target_r <= '0;
      fold_cnt_r <= '0;
      shut_r <= 1'b0;
    end else begin
      target_r <= target_nxt;
      fold_cnt_r <= fold_cnt_nxt;
      shut_r <= shut_nxt;
    end
  end

  // ==========================================================
  // drive registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      suspend_r <= 1'b0;
      drive_r <= '0;
    end else begin
      suspend_r <= suspend_nxt;
      drive_r <= drive_nxt;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      control_r <= charger_pkg::CONTROL_RESET;
      mask_r <= charger_pkg::MASK_RESET[charger_pkg::EV_W-1:0];
      event_r <= '0;
    end else begin
      control_r <= control_nxt;
      mask_r <= mask_nxt;
      event_r <= event_nxt;
    end
  end

  // ==========================================================
  // bus access registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rdata_r <= '0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_drive = drive_r;
  assign o_hrdata = rdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_irq = |(event_r & mask_r);

endmodule : charger_state_control
`default_nettype wire

// ==== rtl/charger_pkg.sv ====
`default_nettype none
package charger_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CONTROL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR = 8'h0c;
  localparam logic [7:0] TIMER_ADDR = 8'h10;

  // ==========================================================
  // control fields
  localparam int CTL_BOOST_BIT = 0;
  localparam int CTL_FC_LSB = 8;
  localparam int FC_W = 8;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_ff00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // ==========================================================
  // event bits
  localparam int EV_STATE = 0;
  localparam int EV_TIMER_FAULT = 1;
  localparam int EV_TEMP_SUSPEND = 2;
  localparam int EV_DIE_SHUTDOWN = 3;
  localparam int EV_W = 4;

  // ==========================================================
  // timing
  localparam int CLOCK_HZ = 100_000_000;
  localparam int PRECHARGE_TIMEOUT_MS = 30;
  localparam int PRECHARGE_TIMEOUT_CYC = PRECHARGE_TIMEOUT_MS * (CLOCK_HZ / 1000);
  localparam int FOLD_STEP_US = 10;
  localparam int FOLD_STEP_CYC = FOLD_STEP_US * (CLOCK_HZ / 1_000_000);
  localparam int TIMER_W = 32;

  typedef enum logic [2:0] {
    ST_DISABLED,
    ST_DEAD_BATTERY,
    ST_PRECHARGE,
    ST_FAST_CC,
    ST_TIMER_FAULT
  } charge_state_t;

  typedef struct packed {
    logic input_valid;
    logic above_low;
    logic above_high;
    logic thermistor_out_of_range;
    logic thermistor_grounded;
    logic die_over_regulation;
    logic die_over_shutdown;
  } sense_t;

  typedef struct packed {
    logic switcher_on;
    logic dead_battery_linear;
    logic system_linear;
    logic boost_on;
    logic [FC_W-1:0] current_target;
  } drive_t;

endpackage : charger_pkg
`default_nettype wire

// ==== rtl/sync2.sv ====
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule : sync2
`default_nettype wire

// ==== test/charger_far_side.sv ====
`default_nettype none
module charger_far_side #(
  parameter int LOW = 40,
  parameter int HIGH = 80
) (
  input wire logic i_valid,
  input wire logic [7:0] i_vbat,
  input wire logic [1:0] i_therm,
  input wire logic [1:0] i_die,
  output var charger_pkg::sense_t o_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // comparators: therm b0 out of range, b1 grounded; die b0 reg, b1 shutdown
  assign o_sense = '{i_valid, i_vbat > LOW, i_vbat > HIGH,
    i_therm[0], i_therm[1], i_die[0], i_die[1]};
endmodule : charger_far_side
`default_nettype wire

// ==== test/charger_state_control_sva.sv ====
`default_nettype none
module charger_state_control_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire charger_pkg::sense_t i_sense,
  input wire charger_pkg::drive_t o_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================
  // six cycles cover sync, state and drive latency
  property p_no_input;
    !i_sense.input_valid [*6] |-> !o_drive.switcher_on
      && !o_drive.dead_battery_linear && !o_drive.system_linear;
  endproperty
  a_no_input: assert property (p_no_input)
    else $error("charging without valid input");
  property p_suspend;
    (i_sense.thermistor_out_of_range && !i_sense.thermistor_grounded) [*6]
      |-> !o_drive.switcher_on && !o_drive.dead_battery_linear;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("charging while thermistor out of range");
  property p_shutdown;
    i_sense.die_over_shutdown [*6] |-> !o_drive.switcher_on
      && !o_drive.system_linear;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("charging above die shutdown");
  property p_fold;
    i_sense.die_over_regulation [*6] |->
      o_drive.current_target <= $past(o_drive.current_target);
  endproperty
  a_fold: assert property (p_fold)
    else $error("target rose while die hot");
  property p_excl;
    o_drive.switcher_on |-> !o_drive.dead_battery_linear
      && !o_drive.system_linear;
  endproperty
  a_excl: assert property (p_excl)
    else $error("switcher and linear path together");
  property p_both;
    o_drive.system_linear |-> o_drive.dead_battery_linear;
  endproperty
  a_both: assert property (p_both)
    else $error("precharge missing a linear path");
  property p_boost_valid;
    i_sense.input_valid [*6] |-> !o_drive.boost_on;
  endproperty
  a_boost_valid: assert property (p_boost_valid)
    else $error("boost with valid input");
  property p_boost_off;
    o_drive.boost_on |-> !o_drive.switcher_on && !o_drive.system_linear;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("boost while charging");
endmodule : charger_state_control_sva
bind charger_state_control charger_state_control_sva i_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_sense(i_sense), .o_drive(o_drive));
`default_nettype wire

// ==== test/charger_state_control_tb.sv ====
`default_nettype none
module charger_state_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0;
  logic i_rst = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic hready;
  logic irq;
  logic hresp;
  logic valid = 0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] therm = 2'h0;
  logic [1:0] die = 2'h0;
  logic [7:0] vbat = 8'h00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [31:0] t;
  charger_pkg::sense_t sense;
  charger_pkg::drive_t drv;
  int fails = 0;
  int n_checks = 0;
  int cyc_n = 0;
  charger_far_side i_far (.i_valid(valid), .i_vbat(vbat), .i_therm(therm),
    .i_die(die), .o_sense(sense));
  charger_state_control #(.PRECHARGE_CYCLES(50)) i_dut (.i_clock(i_clock),
    .i_rst(i_rst), .i_sense(sense), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(rdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_drive(drv), .o_irq(irq));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // ==========================================
  // tasks
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  always @(posedge i_clock) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge i_clock);
  endtask : w
  // single transfer; read data taken at the data-phase edge
  task automatic ahb(input logic [7:0] a, input logic wr,
    input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge i_clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clock); while (hready !== 1'b1);
    d = rdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : ahb
  task automatic st(input logic [2:0] s);
    ahb(charger_pkg::STATUS_ADDR, 1'b0, 32'h0000_0000);
    chk({29'h0, d[2:0]}, {29'h0, s});
  endtask : st
  task automatic pth(input logic [2:0] p);
    chk({29'h0, drv.switcher_on, drv.dead_battery_linear,
      drv.system_linear}, {29'h0, p});
  endtask : pth
  // ==========================================
  // sequence
  initial begin
    w(6);
    chk({20'h0, drv}, 32'h0000_0000);
    i_rst <= 1'b0;
    ahb(charger_pkg::CONTROL_ADDR, 1'b0, 32'h0);
    chk(d, charger_pkg::CONTROL_RESET);
    ahb(8'h14, 1'b0, 32'h0);
    chk(d, 32'h0000_0000);
    ahb(charger_pkg::MASK_ADDR, 1'b1, 32'h0000_0002);
    ahb(charger_pkg::MASK_ADDR, 1'b0, 32'h0);
    chk(d, 32'h0000_0002);
    ahb(charger_pkg::STATUS_ADDR, 1'b1, 32'h0000_0007);
    st(3'h0);
    valid <= 1'b1;
    vbat <= 8'h0a;
    w(6);
    st(3'h1);
    pth(3'h2);
    vbat <= 8'h32;
    w(6);
    st(3'h2);
    pth(3'h3);
    therm <= 2'h1;
    w(6);
    pth(3'h0);
    ahb(charger_pkg::TIMER_ADDR, 1'b0, 32'h0);
    t = d;
    w(20);
    ahb(charger_pkg::TIMER_ADDR, 1'b0, 32'h0);
    chk(d, t);
    st(3'h2);
    chk({30'h0, d[5:4]}, 32'h0000_0002);
    ahb(charger_pkg::EVENT_ADDR, 1'b0, 32'h0);
    chk({30'h0, d[2:1]}, 32'h0000_0002);
    therm <= 2'h0;
    w(10);
    ahb(charger_pkg::TIMER_ADDR, 1'b0, 32'h0);
    chk({31'h0, d > t}, 32'h0000_0001);
    pth(3'h3);
    w(60);
    st(3'h4);
    chk({31'h0, irq}, 32'h0000_0001);
    ahb(charger_pkg::EVENT_ADDR, 1'b1, 32'h0000_0002);
    w(1);
    chk({31'h0, irq}, 32'h0000_0000);
    vbat <= 8'h5a;
    w(6);
    st(3'h4);
    pth(3'h0);
    valid <= 1'b0;
    vbat <= 8'h32;
    w(6);
    valid <= 1'b1;
    w(6);
    st(3'h2);
    ahb(charger_pkg::TIMER_ADDR, 1'b0, 32'h0);
    chk({31'h0, d < 12}, 32'h0000_0001);
    vbat <= 8'h5a;
    w(6);
    st(3'h3);
    pth(3'h4);
    therm <= 2'h3;
    w(6);
    pth(3'h4);
    st(3'h3);
    chk({31'h0, d[5]}, 32'h0000_0000);
    therm <= 2'h0;
    ahb(charger_pkg::CONTROL_ADDR, 1'b1, 32'h0000_0800);
    w(4);
    chk({24'h0, drv.current_target}, 32'h0000_0008);
    die <= 2'h1;
    w(7000);
    chk({24'h0, drv.current_target}, 32'h0000_0002);
    w(1500);
    chk({24'h0, drv.current_target}, 32'h0000_0002);
    die <= 2'h3;
    w(6);
    pth(3'h0);
    st(3'h3);
    chk({30'h0, d[5:4]}, 32'h0000_0001);
    die <= 2'h0;
    valid <= 1'b0;
    w(6);
    chk({31'h0, drv.boost_on}, 32'h0000_0000);
    ahb(charger_pkg::CONTROL_ADDR, 1'b1, 32'h0000_0801);
    w(4);
    chk({31'h0, drv.boost_on}, 32'h0000_0001);
    valid <= 1'b1;
    w(6);
    chk({31'h0, drv.boost_on}, 32'h0000_0000);
    final_report;
  end
endmodule : charger_state_control_tb
`default_nettype wire
